// ---- src/ddr2w_core.sv ----
// ddr2 write capture, precharge, refresh timing and ahb-lite register slave
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ddr2w_core
    import ddr2w_pkg::*;
#(
    parameter int COLW  = 6,
    parameter int ROWW  = 14
) (
    input  wire logic            clk,
    input  wire logic            srst,
    // link pins from the controller
    input  wire logic            ck,
    input  wire logic            cke,
    input  wire logic            cs_n,
    input  wire logic            ras_n,
    input  wire logic            cas_n,
    input  wire logic            we_n,
    input  wire logic [1:0]      ba,
    input  wire logic [ROWW-1:0] addr,
    input  wire logic [15:0]     dq,
    input  wire logic [1:0]      dm,
    input  wire logic [1:0]      dqs,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata
);
    localparam int DEPTH = 4 << COLW;
    localparam int AW    = COLW + 2;

    // =====================================================================
    // pin synchronisers
    // =====================================================================
    logic [2:0]      ck_q;
    logic [4:0]      ctl_s1, ctl_s2;
    logic [1:0]      ba_s1, ba_s2;
    logic [ROWW-1:0] ad_s1, ad_s2;
    logic [15:0]     dq_s1, dq_s2;
    logic [1:0]      dm_s1, dm_s2;
    logic [1:0]      dqs_s1, dqs_s2, dqs_s3;

    // every pin passes two flops; third ck/dqs stage only serves edge finding
    always_ff @(posedge clk) begin
        ck_q   <= {ck_q[1:0], ck};
        ctl_s1 <= {cke, cs_n, ras_n, cas_n, we_n};
        ctl_s2 <= ctl_s1;
        ba_s1  <= ba;
        ba_s2  <= ba_s1;
        ad_s1  <= addr;
        ad_s2  <= ad_s1;
        dq_s1  <= dq;
        dq_s2  <= dq_s1;
        dm_s1  <= dm;
        dm_s2  <= dm_s1;
        dqs_s1 <= dqs;
        dqs_s2 <= dqs_s1;
        dqs_s3 <= dqs_s2;
    end

    // =====================================================================
    // command decode at link clock rise
    // =====================================================================
    logic ck_rise, cmd_ok, is_wr, is_pre, is_ref, is_act, a10;
    assign ck_rise = ck_q[1] & ~ck_q[2];
    assign cmd_ok  = ck_rise & ctl_s2[4] & ~ctl_s2[3];
    assign is_wr   = cmd_ok & (ctl_s2[2:0] == CMD_WRITE);
    assign is_pre  = cmd_ok & (ctl_s2[2:0] == CMD_PRE);
    assign is_ref  = cmd_ok & (ctl_s2[2:0] == CMD_REF);
    assign is_act  = cmd_ok & (ctl_s2[2:0] == CMD_ACT);
    assign a10     = ad_s2[10];

    // =====================================================================
    // registers
    // =====================================================================
    logic [31:0]   ctrl_q, timing_q;
    logic [AW-1:0] maddr_q;
    logic          err_pre_q, err_ref_q;
    logic [15:0]   ref_cnt_q, wr_cnt_q;
    logic          bl8, ilv;
    logic [2:0]    wl;
    logic [3:0]    half_bl, wr_ck, twtr_ck;
    logic [7:0]    trfc_ck;
    assign bl8     = ctrl_q[CTRL_BL8_BIT];
    assign ilv     = ctrl_q[CTRL_ILV_BIT];
    assign wl      = ctrl_q[CTRL_WL_LSB +: 3];
    assign wr_ck   = {1'b0, ctrl_q[CTRL_WR_LSB +: 3]};                  // [R13]
    assign half_bl = bl8 ? 4'h4 : 4'h2;
    assign trfc_ck = timing_q[7:0];
    // spacing never below two link clocks
    assign twtr_ck = (timing_q[11:8] > WTR_MIN_CK) ? timing_q[11:8] : WTR_MIN_CK;

    // =====================================================================
    // write latency pipe: one slot per link clock, so a cutting write two
    // clocks behind the first has its own slot and cannot overwrite it
    // =====================================================================
    logic [WPIPE_DEPTH-1:0] wp_v_q;
    logic [AW-1:0]          wp_a_q [WPIPE_DEPTH];
    logic                   go;
    logic [AW-1:0]          go_a;

    always_ff @(posedge clk) begin
        if (srst) begin
            wp_v_q <= '0;
        end else if (ck_rise) begin
            wp_v_q <= {wp_v_q[WPIPE_DEPTH-2:0], is_wr};
        end
    end
    always_ff @(posedge clk) begin
        if (ck_rise) begin
            wp_a_q[0] <= {ba_s2, ad_s2[COLW-1:0]};
            for (int i = 1; i < WPIPE_DEPTH; i++) begin
                wp_a_q[i] <= wp_a_q[i-1];
            end
        end
    end
    // arm one clock before WL so the first strobe rise is seen after arming
    assign go   = ck_rise & wp_v_q[3'(wl - 3'h2)];                     // [R23]
    assign go_a = wp_a_q[3'(wl - 3'h2)];

    // column order inside the burst, wrapping on the burst boundary
    function automatic logic [COLW-1:0] burst_col(input logic [COLW-1:0] base,
                                                 input logic [2:0] idx,
                                                 input logic b8, input logic il);
        logic [2:0] lo;
        lo = il ? (base[2:0] ^ idx) : 3'(base[2:0] + idx);
        burst_col = b8 ? {base[COLW-1:3], lo} : {base[COLW-1:2], lo[1:0]};
    endfunction

    // =====================================================================
    // byte lanes: each lane owns its strobe, index and storage
    // =====================================================================
    logic [1:0] lane_act, lane_fire;
    logic [7:0] lane_rd [2];

    for (genvar l = 0; l < 2; l++) begin : g_lane
        logic          act_q, pend_q;
        logic [2:0]    idx_q, wi;
        logic [AW-1:0] nxt_a_q, cur_a_q, wa;
        logic [7:0]    mem [DEPTH];
        logic          rise, edge_any, start, fire;
        assign rise     = dqs_s2[l] & ~dqs_s3[l];
        assign edge_any = dqs_s2[l] ^ dqs_s3[l];
        // an arm waits for the next strobe rise, so a cut burst keeps its tail
        assign start    = pend_q & rise;
        assign fire     = start | (act_q & edge_any & (idx_q != 3'h0));
        assign wa       = start ? nxt_a_q : cur_a_q;
        assign wi       = start ? 3'h0 : idx_q;
        assign lane_act[l]  = act_q;
        assign lane_fire[l] = fire;
        assign lane_rd[l]   = mem[maddr_q];

        // strobe outside an armed burst is ignored [R25]
        always_ff @(posedge clk) begin
            if (srst) begin
                pend_q <= 1'b0;
                act_q  <= 1'b0;
                idx_q  <= 3'h0;
            end else begin
                pend_q <= go | (pend_q & ~start);
                if (start) begin
                    act_q <= 1'b1;
                    idx_q <= 3'h1;
                end else if (fire) begin
                    idx_q <= 3'(idx_q + 3'h1);
                    act_q <= (idx_q != 3'(half_bl * 4'h2 - 4'h1));     // [R2]
                end
            end
        end
        // burst addresses; a later arm replaces a waiting one [R7]
        always_ff @(posedge clk) begin
            if (go) nxt_a_q <= go_a;
            if (start) cur_a_q <= nxt_a_q;
        end
        // own strobe takes own byte; a masked element is skipped [R15]
        always_ff @(posedge clk) begin
            if (fire && !dm_s2[l]) begin
                mem[{wa[AW-1:COLW],
                     burst_col(wa[COLW-1:0], wi, bl8, ilv)}] <= dq_s2[8*l +: 8];
            end
        end
    end

    // =====================================================================
    // bank state, write recovery and write-to-read spacing
    // =====================================================================
    logic [3:0] bank_open_q, ap_pend_q;
    logic [4:0] wr_rem_q [4];
    logic [4:0] wtr_rem_q, rec_load;
    logic [3:0] wrb;
    // recovery is counted from the full programmed burst end, mask or not
    assign rec_load = 5'(4'(wl) + half_bl) + 5'(wr_ck);                 // [R6] [R14]

    for (genvar b = 0; b < 4; b++) begin : g_bank
        assign wrb[b] = (wr_rem_q[b] != 5'h0);
        // tWR starts WL+BL/2 clocks after the write, then runs tWR more [R11]
        always_ff @(posedge clk) begin
            if (srst) begin
                wr_rem_q[b] <= 5'h0;
                ap_pend_q[b] <= 1'b0;
            end else if (is_wr && ba_s2 == 2'(b)) begin
                wr_rem_q[b]  <= rec_load;
                ap_pend_q[b] <= a10;
            end else if (ck_rise && wrb[b]) begin
                wr_rem_q[b] <= 5'(wr_rem_q[b] - 5'h1);
                if (wr_rem_q[b] == 5'h1) begin
                    ap_pend_q[b] <= 1'b0;
                end
            end
        end
    end

    // open rows: activate opens, precharge and auto precharge close [R16]
    always_ff @(posedge clk) begin
        if (srst) begin
            bank_open_q <= 4'h0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (is_act && ba_s2 == 2'(b)) begin
                    bank_open_q[b] <= 1'b1;
                end else if (is_pre && (a10 || ba_s2 == 2'(b))) begin
                    bank_open_q[b] <= 1'b0;
                end else if (ck_rise && ap_pend_q[b] && wr_rem_q[b] == 5'h1) begin
                    bank_open_q[b] <= 1'b0;
                end
            end
        end
    end

    // tWTR from the first clock after the last data pair [R9]
    always_ff @(posedge clk) begin
        if (srst) begin
            wtr_rem_q <= 5'h0;
        end else if (is_wr) begin
            wtr_rem_q <= 5'(4'(wl) + half_bl) + 5'(twtr_ck);
        end else if (ck_rise && wtr_rem_q != 5'h0) begin
            wtr_rem_q <= 5'(wtr_rem_q - 5'h1);
        end
    end

    // =====================================================================
    // refresh occupancy
    // =====================================================================
    logic [7:0] ref_rem_q;
    logic       ref_busy;
    assign ref_busy = (ref_rem_q != 8'h0);
    // busy from the registering edge until tRFC clocks have passed [R20]
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_rem_q <= 8'h0;
        end else if (is_ref) begin
            ref_rem_q <= trfc_ck;
        end else if (ck_rise && ref_busy) begin
            ref_rem_q <= 8'(ref_rem_q - 8'h1);
        end
    end

    // =====================================================================
    // ahb-lite slave, zero wait states
    // =====================================================================
    logic       dp_v_q, dp_wr_q;
    logic [7:0] dp_a_q;
    logic       ap_take, st_clr_pre, st_clr_ref;
    logic [31:0] rd_mux;
    assign ap_take   = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge clk) begin
        if (srst) begin
            dp_v_q  <= 1'b0;
            dp_wr_q <= 1'b0;
            dp_a_q  <= 8'h00;
        end else if (hready) begin
            dp_v_q  <= ap_take;
            dp_wr_q <= hwrite;
            dp_a_q  <= {haddr[7:2], 2'b00};
        end
    end

    // register writes land in the data phase
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q   <= CTRL_RST;
            timing_q <= TIMING_RST;
            maddr_q  <= '0;
        end else if (dp_v_q && dp_wr_q) begin
            case (dp_a_q)
                REG_CTRL:   ctrl_q   <= hwdata & 32'h0000_0E73;
                REG_TIMING: timing_q <= hwdata & 32'h0000_0FFF;
                REG_MADDR:  maddr_q  <= hwdata[AW-1:0];
                default:    ;
            endcase
        end
    end

    assign st_clr_pre = dp_v_q & dp_wr_q & (dp_a_q == REG_STATUS) & hwdata[ST_ERRPRE_BIT];
    assign st_clr_ref = dp_v_q & dp_wr_q & (dp_a_q == REG_STATUS) & hwdata[ST_ERRREF_BIT];

    // sticky misuse flags; a new event beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (srst) begin
            err_pre_q <= 1'b0;
            err_ref_q <= 1'b0;
        end else begin
            if (is_pre && (a10 ? (wrb != 4'h0) : wrb[ba_s2])) begin
                err_pre_q <= 1'b1;
            end else if (st_clr_pre) begin
                err_pre_q <= 1'b0;
            end
            if (is_ref && (bank_open_q != 4'h0 || ref_busy)) begin
                err_ref_q <= 1'b1;
            end else if (st_clr_ref) begin
                err_ref_q <= 1'b0;
            end
        end
    end

    // event counters, wrap silently
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_cnt_q <= 16'h0000;
            wr_cnt_q  <= 16'h0000;
        end else begin
            if (is_ref) ref_cnt_q <= 16'(ref_cnt_q + 16'h0001);
            if (is_wr)  wr_cnt_q  <= 16'(wr_cnt_q + 16'h0001);
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case ({haddr[7:2], 2'b00})
            REG_CTRL:   rd_mux = ctrl_q;
            REG_TIMING: rd_mux = timing_q;
            REG_STATUS: begin
                rd_mux[3:0]           = bank_open_q;
                rd_mux[ST_REF_BIT]    = ref_busy;
                rd_mux[ST_BURST_BIT]  = |lane_act;
                rd_mux[ST_WTR_BIT]    = (wtr_rem_q != 5'h0);
                rd_mux[ST_WRB_LSB +: 4] = wrb;
                rd_mux[ST_ERRPRE_BIT] = err_pre_q;
                rd_mux[ST_ERRREF_BIT] = err_ref_q;
            end
            REG_COUNT:  rd_mux = {wr_cnt_q, ref_cnt_q};
            REG_MADDR:  rd_mux = 32'(maddr_q);
            REG_MDATA:  rd_mux = {16'h0000, lane_rd[1], lane_rd[0]};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is sampled at the address phase and held for the data phase
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // =====================================================================
    // assertions
    // =====================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_pre_all_close: assert property (is_pre && a10 |=> bank_open_q == 4'h0) // [R16]
        else $error("precharge all left a bank open");
    a_pre_one_close: assert property (is_pre && !a10 && !is_act
        |=> !bank_open_q[$past(ba_s2)]
            && ((bank_open_q | (4'h1 << $past(ba_s2)))
                == ($past(bank_open_q) | (4'h1 << $past(ba_s2))))) // [R16]
        else $error("single precharge touched the wrong bank");
    a_rec_load_val: assert property (is_wr
        |=> wr_rem_q[$past(ba_s2)] == 5'($past(4'(wl) + half_bl)) + 5'($past(wr_ck))) // [R6]
        else $error("write recovery not loaded with WL+BL/2+WR");
    a_rec_hold_nock: assert property (!ck_rise && !is_wr && wrb[0] |=> $stable(wr_rem_q[0])) // [R11]
        else $error("recovery moved without a link clock edge");
    a_wtr_floor: assert property (is_wr |=> wtr_rem_q >= 5'($past(4'(wl) + half_bl)) + 5'h2) // [R9]
        else $error("write to read spacing below two clocks");
    a_ref_busy_len: assert property (is_ref && trfc_ck != 8'h0
        |=> ref_busy && ref_rem_q == $past(trfc_ck)) // [R20]
        else $error("refresh occupancy not started");
    a_idle_no_cap: assert property (!lane_act[0] && !g_lane[0].pend_q |-> !lane_fire[0]) // [R25]
        else $error("lower lane captured outside a burst");
    a_first_rise: assert property (lane_fire[1] && !lane_act[1] |-> dqs_s2[1]) // [R23]
        else $error("first element taken on a falling strobe");
    a_burst_count: assert property (lane_fire[0] && g_lane[0].idx_q == 3'(half_bl * 4'h2 - 4'h1)
        && !go |=> !lane_act[0]) // [R2]
        else $error("burst did not end after BL elements");
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout)
        else $error("slave response not OKAY");

    c_write_burst: cover property ($fell(lane_act[0]));
    c_cut_write:   cover property (go && lane_act[0] && bl8);
    c_refresh:     cover property (is_ref ##[1:40] !ref_busy);
    c_pre_all:     cover property (is_pre && a10 && bank_open_q == 4'hF);
endmodule // ddr2w_core
`default_nettype wire

// ---- shared/ddr2w_pkg.sv ----
// constants, register map and command codes of the ddr2 write/precharge/refresh block
// What the document requires
// R1: controller keeps later rising strobe edges inside tDQSS of their clock edge.
// R2: burst of four takes the start column then three more in burst order.
// R3: only a burst-of-eight write without auto precharge may be cut by a write.
// R4: the cutting write comes exactly two clocks after the cut write.
// R5: only idle commands between the two writes; no precharge to their banks.
// R6: cut eight-burst recovery counts from the full burst end, WL+BL/2+tWR.
// R7: the cutting write may target any bank and row, auto precharge either way.
// R8: controller waits tWTR before a read to the same device after a write.
// R9: tWTR counts from the first clock edge after the last data pair.
// R10: write-to-read spacing is the larger of two clocks and tWTR/tCK.
// R11: tWR counts from the first clock edge after the last data pair.
// R12: precharge to an unwritten bank need not wait tWR.
// R13: recovery field in mode bits 11:9 holds tWR/tCK rounded up.
// R14: recovery starts at burst end regardless of data masking.
// R15: lower strobe captures the lower byte, upper strobe the upper byte.
// R16: precharge with A10 high closes all banks, low closes the addressed bank.
// R17: a precharged bank must be activated before reads or writes.
// R18: controller waits tRP after single precharge and tRPA after precharge all.
// R19: refresh at most every 7.8125us average, every row within 64ms.
// R20: refresh keeps the device busy from its command for tRFC.
// R21: above +85C the average refresh interval shrinks to 3.9us.
// R22: banks closed before refresh, precharge all if several open; CKE high.
// R23: write latency is read latency minus one; data on successive strobe edges.
// R24: burst of four never cut; eight only by a write on a four boundary.
// R25: data, mask and strobe are ignored while refresh or precharge run.
package ddr2w_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TIMING = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_COUNT  = 8'h0C;
    localparam logic [7:0] REG_MADDR  = 8'h10;
    localparam logic [7:0] REG_MDATA  = 8'h14;
    // control field positions
    localparam int CTRL_BL8_BIT = 0;
    localparam int CTRL_ILV_BIT = 1;
    localparam int CTRL_WL_LSB  = 4;
    localparam int CTRL_WR_LSB  = 9;
    // status field positions
    localparam int ST_REF_BIT    = 4;
    localparam int ST_BURST_BIT  = 5;
    localparam int ST_WTR_BIT    = 6;
    localparam int ST_WRB_LSB    = 8;
    localparam int ST_ERRPRE_BIT = 16;
    localparam int ST_ERRREF_BIT = 17;
    // link timing, figures in ns, counts in link clocks
    localparam int TCK_NS  = 80;
    localparam int TWR_NS  = 15;
    localparam int TWTR_NS = 10;
    localparam int TRFC_NS = 105;
    localparam int WR_CK   = (TWR_NS + TCK_NS - 1) / TCK_NS;
    localparam int WTR_CK  = (TWTR_NS + TCK_NS - 1) / TCK_NS;
    localparam int RFC_CK  = (TRFC_NS + TCK_NS - 1) / TCK_NS;
    localparam logic [3:0] WTR_MIN_CK = 4'h2;
    // reset values
    localparam logic [2:0] WL_RST = 3'h2;
    localparam logic [31:0] CTRL_RST = (32'(WL_RST) << CTRL_WL_LSB)
                                     | (32'(WR_CK) << CTRL_WR_LSB);
    localparam logic [31:0] TIMING_RST = 32'(RFC_CK) | (32'(WTR_CK) << 8);
    // command codes {ras_n, cas_n, we_n} with chip select low
    localparam logic [2:0] CMD_WRITE = 3'h5;
    localparam logic [2:0] CMD_PRE   = 3'h2;
    localparam logic [2:0] CMD_REF   = 3'h1;
    localparam logic [2:0] CMD_ACT   = 3'h3;
    localparam int WPIPE_DEPTH = 8;
endpackage

// ---- verif/ddr2w_ctl_model.sv ----
// controller model driving commands and write data on the link pins
`timescale 1ns/1ps
`default_nettype none
module ddr2w_ctl_model #(
    parameter int WL = 2
) (
    output logic        ck,
    output logic        cke,
    output logic        cs_n,
    output logic        ras_n,
    output logic        cas_n,
    output logic        we_n,
    output logic [1:0]  ba,
    output logic [13:0] addr,
    output logic [15:0] dq,
    output logic [1:0]  dm,
    output logic [1:0]  dqs
);
    // ==========================================================
    // link clock, free running once reset has settled
    initial begin
        {ck, cke, cs_n, ras_n, cas_n, we_n} = 6'h1F; // cke stays high
        {ba, addr, dq, dm, dqs} = '0;
        #203;
        forever #40 ck = ~ck;
    end
    // command set at a falling edge, deselected after one rising edge
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [13:0] a);
        @(negedge ck);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(posedge ck);
        @(negedge ck);
        cs_n = 1'b1;
    endtask
    // strobe edges sit on clock edges; data leads each edge by 20 ns
    task automatic burst(input int n, input logic [17:0] e [16]);
        repeat (WL - 1) @(posedge ck);
        @(negedge ck);
        for (int k = 0; k < n; k++) begin
            #20 {dm, dq} = e[k];
            #20 dqs = {2{~k[0]}};
        end
        // released lanes show the inverse so stale data never looks valid
        #20 {dm, dq} = ~{dm, dq};
    endtask
endmodule // ddr2w_ctl_model
`default_nettype wire

// ---- verif/ddr2_write_precharge_refresh_test.sv ----
// self-checking bench of the ddr2 write, precharge and refresh block
`timescale 1ns/1ps
`default_nettype none
module ddr2_write_precharge_refresh_test
    import ddr2w_pkg::*;
;
    // ==========================================================
    // signals and instances
    localparam logic [3:0] WRC = {1'b0, CMD_WRITE};
    localparam logic [3:0] PRC = {1'b0, CMD_PRE};
    localparam logic [3:0] RFC = {1'b0, CMD_REF};
    localparam logic [3:0] ACC = {1'b0, CMD_ACT};
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd, v;
    logic        hreadyout, hresp, b8, il, ck, cke, cs_n, ras_n, cas_n, we_n;
    logic [1:0]  ba, dm, dqs;
    logic [13:0] addr;
    logic [15:0] dq;
    logic [15:0] mem [256];
    logic [7:0]  idx [16];
    logic [17:0] e [16];
    logic [31:0] seed = 32'h785c_2810;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          nw = 0;
    wire logic   hready;
    assign hready = hreadyout;
    always #5 clk = ~clk;
    ddr2w_core i_dut (.clk, .srst, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
        .dq, .dm, .dqs, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hreadyout, .hresp, .hrdata);
    ddr2w_ctl_model u_ctl (.ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .dq,
        .dm, .dqs);
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d, checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // single word transfer; waits on hready, no latency assumed
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        ahb(1'b0, a, 32'h0);
        check(rd & m, x);
    endtask
    // burst elements and expected array contents, masked lanes keep old bytes
    task automatic fill(input logic [1:0] b, input logic [5:0] c, input int n, input int o,
                        input logic mk);
        logic [2:0] s;
        for (int k = 0; k < n; k++) begin
            s = il ? c[2:0] ^ 3'(k) : b8 ? c[2:0] + 3'(k) : {c[2], c[1:0] + 2'(k)};
            idx[o + k] = {b, c[5:3], s};
            e[o + k] = 18'(rnd()) & {mk, mk, 16'hFFFF};
            if (!e[o + k][16]) mem[idx[o + k]][7:0] = e[o + k][7:0];
            if (!e[o + k][17]) mem[idx[o + k]][15:8] = e[o + k][15:8];
        end
    endtask
    task automatic wr(input logic [1:0] b, input logic [5:0] c, input logic mk);
        fill(b, c, b8 ? 8 : 4, 0, mk);
        nw++;
        u_ctl.cmd(WRC, b, {8'h00, c});
        u_ctl.burst(b8 ? 8 : 4, e);
    endtask
    task automatic rb(input int n);
        for (int k = 0; k < n; k++) begin
            ahb(1'b1, REG_MADDR, {24'h0, idx[k]});
            rc(REG_MDATA, 32'hFFFF_FFFF, {16'h0, mem[idx[k]]});
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rc(REG_CTRL, '1, CTRL_RST);
        rc(REG_TIMING, '1, TIMING_RST);
        rc(REG_STATUS, '1, 32'h0);
        ahb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        rc(8'h3C, '1, 32'h0);
        check({30'h0, hreadyout, hresp}, 32'h2);
        v = rnd();
        ahb(1'b1, REG_CTRL, v);
        rc(REG_CTRL, '1, v & 32'h0000_0E73);
        {il, b8} = 2'b01;
        ahb(1'b1, REG_CTRL, CTRL_RST | 32'h1);
        for (int b = 0; b < 4; b++) u_ctl.cmd(ACC, 2'(b), 14'h0);
        rc(REG_STATUS, 32'hF, 32'hF);
        // whole array written once so masked bytes are known
        for (int i = 0; i < 32; i++) begin
            wr(2'(i >> 3), {3'(i), 3'h0}, 1'b0);
            rb(8);
        end
        for (int i = 0; i < 10; i++) begin
            v = rnd();
            {il, b8} = v[1:0];
            ahb(1'b1, REG_CTRL, CTRL_RST | {30'h0, v[1:0]});
            wr(v[5:4], v[13:8], 1'b1);
            rb(b8 ? 8 : 4);
        end
        // recovery stretched to five clocks so both precharges land inside it
        {il, b8} = 2'b00;
        ahb(1'b1, REG_CTRL, 32'h0000_0A20);
        wr(2'h1, 6'h05, 1'b1);
        u_ctl.cmd(PRC, 2'h2, 14'h0);
        rc(REG_STATUS, 32'h0001_020F, 32'h0000_020B);
        u_ctl.cmd(PRC, 2'h1, 14'h0);
        rc(REG_STATUS, 32'h0001_020F, 32'h0001_0209);
        repeat (4) @(posedge ck);
        ahb(1'b1, REG_STATUS, 32'h0001_0000);
        rc(REG_STATUS, 32'h0003_0F0F, 32'h0000_0009);
        rb(4);
        u_ctl.cmd(PRC, 2'h2, 14'h0400);
        rc(REG_STATUS, 32'hF, 32'h0);
        u_ctl.cmd(RFC, 2'h0, 14'h0);
        rc(REG_STATUS, 32'h0003_0010, 32'h0000_0010);
        repeat (3) @(posedge ck);
        rc(REG_STATUS, 32'h0000_0010, 32'h0);
        u_ctl.cmd(ACC, 2'h0, 14'h0);
        u_ctl.cmd(RFC, 2'h0, 14'h0);
        rc(REG_STATUS, 32'h0002_0000, 32'h0002_0000);
        ahb(1'b1, REG_STATUS, 32'h0002_0000);
        repeat (3) @(posedge ck);
        u_ctl.cmd(ACC, 2'h3, 14'h0);
        // eight-burst cut after four elements by an auto-precharge write
        {il, b8} = 2'b01;
        ahb(1'b1, REG_CTRL, CTRL_RST | 32'h1);
        fill(2'h0, 6'h10, 4, 0, 1'b0);
        fill(2'h3, 6'h23, 8, 4, 1'b0);
        nw += 2;
        u_ctl.cmd(WRC, 2'h0, 14'h0010);
        fork
            u_ctl.cmd(WRC, 2'h3, 14'h0423);
            u_ctl.burst(12, e);
            begin
                repeat (6) @(posedge ck);
                rc(REG_STATUS, 32'h0000_0100, 32'h0000_0100);
            end
        join
        rc(REG_STATUS, 32'h0000_0900, 32'h0000_0800);
        repeat (4) @(posedge ck);
        rc(REG_STATUS, 32'h0000_0009, 32'h0000_0001);
        rb(12);
        rc(REG_COUNT, 32'hFFFF_FFFF, {16'(nw), 16'h0002});
        close_out();
    end
    // hang guard: sequence needs about 40 us
    initial begin
        #400_000;
        n_mismatch++;
        close_out();
    end
endmodule // ddr2_write_precharge_refresh_test
`default_nettype wire
